// ===== pkg/peak_det_pkg.sv
/*
  constants, register map and field layout of the block peak detector.
  assumes one 40 MHz clock and an APB master reaching the registers.
*/
// What this block does
// [R1] block length is 17-bit unsigned reduced-sample count
// [R2] reduced sample is max of eight samples
// [R3] host: 4x/6x complex length multiple of five
// [R4] host: 8x-32x complex length multiple of ten
// [R5] four thresholds scaled 0 to 256 full
// [R6] flag sets when peak exceeds upper threshold
// [R7] flag clears after continuous hold below lower
// [R8] hold is 16-bit count of reduced ticks
// [R9] host: hold zero when crossing detector used
// [R10] select clear feeds high pair only
// [R11] select set feeds minus one, zero, one
// [R12] detection runs only while enable bit set
// [R13] compare once per block, then restart peak
`default_nettype none
package peak_det_pkg;
  localparam int GROUP_LEN   = 8;
  localparam int BLOCK_LEN_W = 17;
  localparam int HOLD_W      = 16;
  localparam int TH_W        = 8;
  localparam int PEAK_W      = 9;
  localparam int FULL_SCALE  = 256;
  localparam int STAT_W      = 5;
  localparam int CLK_HZ      = 40_000_000;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ENABLE  = 8'h00;
  localparam logic [7:0] IDX_LEN_LO  = 8'h01;
  localparam logic [7:0] IDX_LEN_MID = 8'h02;
  localparam logic [7:0] IDX_LEN_MSB = 8'h03;
  localparam logic [7:0] IDX_HI_UP   = 8'h07;
  localparam logic [7:0] IDX_HI_LOW  = 8'h08;
  localparam logic [7:0] IDX_LO_UP   = 8'h09;
  localparam logic [7:0] IDX_LO_LOW  = 8'h0a;
  localparam logic [7:0] IDX_HOLD_LO = 8'h0b;
  localparam logic [7:0] IDX_HOLD_HI = 8'h0c;
  localparam logic [7:0] IDX_IIR_SEL = 8'h0d;
  localparam logic [7:0] IDX_STATUS  = 8'h20;
  localparam logic [7:0] IDX_MASK    = 8'h21;
  localparam logic [7:0] IDX_PEAK    = 8'h22;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic       RST_BIT  = 1'b0;

  // status and mask bit positions
  localparam int ST_BLOCK  = 0;
  localparam int ST_HI_SET = 1;
  localparam int ST_HI_CLR = 2;
  localparam int ST_LO_SET = 3;
  localparam int ST_LO_CLR = 4;

  // peak readback fields
  localparam int PK_HI_FLAG = 16;
  localparam int PK_LO_FLAG = 17;

  // iir feed codes, two's complement
  localparam logic [1:0] IIR_POS  = 2'h1;
  localparam logic [1:0] IIR_ZERO = 2'h0;
  localparam logic [1:0] IIR_NEG  = 2'h3;
endpackage : peak_det_pkg
`default_nettype wire

// ===== pkg/detect_if.sv
/*
  block result bus from the block accumulator to the hysteresis pairs.
  assumes both ends sit on pclk.
*/
`timescale 1ns/10ps
`default_nettype none
interface detect_if
  import peak_det_pkg::*;
  ();
  logic              tick;
  logic              block_done;
  logic [PEAK_W-1:0] block_peak;
  modport src (output tick, output block_done, output block_peak);
  modport dst (input tick, input block_done, input block_peak);
endinterface : detect_if
`default_nettype wire

// ===== logic/group_max.sv
/*
  folds each group of eight samples into one scaled magnitude maximum.
  assumes samples arrive on pclk with a valid strobe, signed two's complement.
*/
`timescale 1ns/10ps
`default_nettype none
module group_max
  import peak_det_pkg::*;
#(
  parameter int SAMPLE_W = 14
)(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                run,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample,
  output logic                     reduced_valid,
  output logic [PEAK_W-1:0]        reduced
);
  logic [SAMPLE_W-1:0] mag;
  logic [PEAK_W-1:0]   scaled;
  logic [PEAK_W-1:0]   grp_max;
  logic [PEAK_W-1:0]   next_max;
  logic [2:0]          grp_cnt;

  // magnitude of the most negative code reaches full scale exactly
  assign mag    = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : sample;
  assign scaled = PEAK_W'(mag >> (SAMPLE_W - PEAK_W)); // [R5]
  assign next_max = (grp_cnt == 3'h0 || scaled > grp_max) ? scaled : grp_max;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      grp_cnt       <= 3'h0;
      grp_max       <= '0;
      reduced       <= '0;
      reduced_valid <= 1'b0;
    end
    else if (!run)
    begin
      grp_cnt       <= 3'h0;
      reduced_valid <= 1'b0;
    end
    else
    begin
      reduced_valid <= 1'b0;
      if (sample_valid)
      begin
        grp_cnt <= grp_cnt + 3'h1;
        grp_max <= next_max;
        if (grp_cnt == 3'(GROUP_LEN - 1)) // [R2]
        begin
          reduced       <= next_max;
          reduced_valid <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_group_of_eight: assert property ( // [R2]
    reduced_valid |-> $past(grp_cnt) == 3'h7 && $past(sample_valid))
    else $error("reduced sample not after eighth sample");
  a_group_is_max: assert property ( // [R2]
    reduced_valid |-> reduced >= $past(scaled))
    else $error("reduced sample below last sample");
  a_scale_range: assert property ( // [R5]
    reduced_valid |-> reduced <= PEAK_W'(FULL_SCALE))
    else $error("reduced sample above full scale");
endmodule : group_max
`default_nettype wire

// ===== logic/pair_hyst.sv
/*
  one upper/lower threshold pair with a hold-time release.
  assumes block results arrive over detect_if on pclk.
*/
`timescale 1ns/10ps
`default_nettype none
module pair_hyst
  import peak_det_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              run,
  detect_if.dst                  det,
  input  wire logic [TH_W-1:0]   upper,
  input  wire logic [TH_W-1:0]   lower,
  input  wire logic [HOLD_W-1:0] hold,
  output logic                   flag,
  output logic                   set_evt,
  output logic                   clr_evt
);
  logic              below;
  logic [HOLD_W:0]   cnt;
  logic              over;
  logic              under;
  logic              hold_done;

  assign over  = det.block_peak > {1'b0, upper}; // [R6]
  assign under = det.block_peak < {1'b0, lower}; // [R7]
  assign hold_done = (cnt + 1'b1) >= {1'b0, hold}; // [R8]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag    <= 1'b0;
      below   <= 1'b0;
      cnt     <= '0;
      set_evt <= 1'b0;
      clr_evt <= 1'b0;
    end
    else if (!run)
    begin
      flag    <= 1'b0;
      below   <= 1'b0;
      cnt     <= '0;
      set_evt <= 1'b0;
      clr_evt <= 1'b0;
    end
    else
    begin
      set_evt <= 1'b0;
      clr_evt <= 1'b0;
      if (det.block_done)
      begin
        cnt <= '0;
        if (over)
        begin
          flag    <= 1'b1; // [R6]
          set_evt <= !flag;
          below   <= 1'b0;
        end
        else if (under)
        begin
          // a fresh dip restarts the hold; an ongoing one counts this tick too
          below <= 1'b1;
          if (flag && (hold == '0 || (below && hold_done)))
          begin
            flag    <= 1'b0; // [R7]
            clr_evt <= 1'b1;
          end
          else if (flag && below)
            cnt <= cnt + 1'b1; // [R8]
        end
        else
          below <= 1'b0; // [R7]
      end
      else if (det.tick && flag && below)
      begin
        if (hold_done)
        begin
          flag    <= 1'b0; // [R7]
          clr_evt <= 1'b1;
        end
        else
          cnt <= cnt + 1'b1; // [R8]
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flag_sets: assert property ( // [R6]
    run && det.block_done && over |=> flag)
    else $error("flag not set above upper threshold");
  a_flag_release: assert property ( // [R7]
    $fell(flag) && $past(run) |-> $past(below) || $past(under))
    else $error("flag cleared without staying below");
  a_hold_step: assert property ( // [R8]
    run && flag && below && det.tick && !det.block_done && !hold_done
    |=> flag && cnt == $past(cnt) + 1'b1)
    else $error("hold counter did not advance");
endmodule : pair_hyst
`default_nettype wire

// ===== logic/block_peak_detector.sv
/*
  block peak power detector with APB registers, hysteresis flags,
  iir feed and a level interrupt.
  assumes samples and APB both on pclk; zero-wait APB slave.
*/
`timescale 1ns/10ps
`default_nettype none
module block_peak_detector
  import peak_det_pkg::*;
#(
  parameter int SAMPLE_W = 14,
  parameter int ADDR_W   = 12
)(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample,
  output logic                     high_flag,
  output logic                     low_flag,
  output logic [1:0]               iir_feed,
  output logic                     iir_feed_valid,
  output logic                     irq
);
  // configuration
  logic                   peak_detector_enable;
  logic [BLOCK_LEN_W-1:0] peak_block_length;
  logic [TH_W-1:0]        high_pair_upper_threshold;
  logic [TH_W-1:0]        high_pair_lower_threshold;
  logic [TH_W-1:0]        low_pair_upper_threshold;
  logic [TH_W-1:0]        low_pair_lower_threshold;
  logic [HOLD_W-1:0]      flag_release_hold_time;
  logic                   iir_input_select;
  logic [STAT_W-1:0]      status;
  logic [STAT_W-1:0]      mask;

  // datapath
  logic                   red_valid;
  logic [PEAK_W-1:0]      reduced;
  logic [PEAK_W-1:0]      acc;
  logic [PEAK_W-1:0]      next_acc;
  logic [BLOCK_LEN_W-1:0] blk_cnt;
  logic [BLOCK_LEN_W-1:0] len_eff;
  logic                   last;
  logic [PEAK_W-1:0]      last_peak;
  logic [STAT_W-1:0]      events;
  logic                   hi_set;
  logic                   hi_clr;
  logic                   lo_set;
  logic                   lo_clr;

  // bus
  logic                   setup;
  logic                   access;
  logic                   wr_en;
  logic                   mapped;
  logic [31:0]            next_rdata;
  logic                   next_mapped;
  logic                   status_rd;

  detect_if det ();

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = a[1:0] == 2'h0 && a[ADDR_W-1:2] == (ADDR_W-2)'(idx);
  endfunction : hit

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign wr_en  = access && pwrite && pstrb[0] && mapped;
  assign status_rd = access && !pwrite && hit(paddr, IDX_STATUS);

  always_comb
  begin
    next_rdata  = 32'h0000_0000;
    next_mapped = 1'b1;
    if (hit(paddr, IDX_ENABLE))
      next_rdata[0] = peak_detector_enable;
    else if (hit(paddr, IDX_LEN_LO))
      next_rdata[7:0] = peak_block_length[7:0];
    else if (hit(paddr, IDX_LEN_MID))
      next_rdata[7:0] = peak_block_length[15:8];
    else if (hit(paddr, IDX_LEN_MSB))
      next_rdata[0] = peak_block_length[16];
    else if (hit(paddr, IDX_HI_UP))
      next_rdata[7:0] = high_pair_upper_threshold;
    else if (hit(paddr, IDX_HI_LOW))
      next_rdata[7:0] = high_pair_lower_threshold;
    else if (hit(paddr, IDX_LO_UP))
      next_rdata[7:0] = low_pair_upper_threshold;
    else if (hit(paddr, IDX_LO_LOW))
      next_rdata[7:0] = low_pair_lower_threshold;
    else if (hit(paddr, IDX_HOLD_LO))
      next_rdata[7:0] = flag_release_hold_time[7:0];
    else if (hit(paddr, IDX_HOLD_HI))
      next_rdata[7:0] = flag_release_hold_time[15:8];
    else if (hit(paddr, IDX_IIR_SEL))
      next_rdata[0] = iir_input_select;
    else if (hit(paddr, IDX_STATUS))
      next_rdata[STAT_W-1:0] = status;
    else if (hit(paddr, IDX_MASK))
      next_rdata[STAT_W-1:0] = mask;
    else if (hit(paddr, IDX_PEAK))
    begin
      next_rdata[PEAK_W-1:0] = last_peak;
      next_rdata[PK_HI_FLAG] = high_flag;
      next_rdata[PK_LO_FLAG] = low_flag;
    end
    else
      next_mapped = 1'b0;
  end

  // read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      mapped <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= next_rdata;
      mapped <= next_mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      peak_detector_enable      <= RST_BIT;
      peak_block_length         <= '0;
      high_pair_upper_threshold <= RST_BYTE;
      high_pair_lower_threshold <= RST_BYTE;
      low_pair_upper_threshold  <= RST_BYTE;
      low_pair_lower_threshold  <= RST_BYTE;
      flag_release_hold_time    <= '0;
      iir_input_select          <= RST_BIT;
      mask                      <= '0;
    end
    else if (wr_en)
    begin
      if (hit(paddr, IDX_ENABLE))
        peak_detector_enable <= pwdata[0];
      if (hit(paddr, IDX_LEN_LO))
        peak_block_length[7:0] <= pwdata[7:0];
      if (hit(paddr, IDX_LEN_MID))
        peak_block_length[15:8] <= pwdata[7:0];
      if (hit(paddr, IDX_LEN_MSB))
        peak_block_length[16] <= pwdata[0]; // [R1]
      if (hit(paddr, IDX_HI_UP))
        high_pair_upper_threshold <= pwdata[7:0];
      if (hit(paddr, IDX_HI_LOW))
        high_pair_lower_threshold <= pwdata[7:0];
      if (hit(paddr, IDX_LO_UP))
        low_pair_upper_threshold <= pwdata[7:0];
      if (hit(paddr, IDX_LO_LOW))
        low_pair_lower_threshold <= pwdata[7:0];
      if (hit(paddr, IDX_HOLD_LO))
        flag_release_hold_time[7:0] <= pwdata[7:0];
      if (hit(paddr, IDX_HOLD_HI))
        flag_release_hold_time[15:8] <= pwdata[7:0];
      if (hit(paddr, IDX_IIR_SEL))
        iir_input_select <= pwdata[0];
      if (hit(paddr, IDX_MASK))
        mask <= pwdata[STAT_W-1:0];
    end
  end

  group_max #(
    .SAMPLE_W      (SAMPLE_W)
  ) u_group (
    .pclk          (pclk),
    .presetn       (presetn),
    .run           (peak_detector_enable),
    .sample_valid  (sample_valid),
    .sample        (sample),
    .reduced_valid (red_valid),
    .reduced       (reduced)
  );

  // a zero length would wrap to a block of 131072 reduced samples, so it acts as one
  assign len_eff  = (peak_block_length == '0) ? BLOCK_LEN_W'(1)
                                              : peak_block_length; // [R1]
  assign last     = blk_cnt >= len_eff - BLOCK_LEN_W'(1);
  assign next_acc = (blk_cnt == '0 || reduced > acc) ? reduced : acc;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blk_cnt        <= '0;
      acc            <= '0;
      det.block_done <= 1'b0;
      det.block_peak <= '0;
      det.tick       <= 1'b0;
    end
    else if (!peak_detector_enable) // [R12]
    begin
      blk_cnt        <= '0;
      acc            <= '0;
      det.block_done <= 1'b0;
      det.tick       <= 1'b0;
    end
    else
    begin
      det.tick       <= red_valid; // [R8]
      det.block_done <= red_valid && last; // [R13]
      if (red_valid)
      begin
        if (last)
        begin
          det.block_peak <= next_acc; // [R13]
          blk_cnt        <= '0;
          acc            <= '0;
        end
        else
        begin
          acc     <= next_acc;
          blk_cnt <= blk_cnt + BLOCK_LEN_W'(1); // [R1]
        end
      end
    end
  end

  pair_hyst u_high (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (peak_detector_enable),
    .det     (det),
    .upper   (high_pair_upper_threshold),
    .lower   (high_pair_lower_threshold),
    .hold    (flag_release_hold_time),
    .flag    (high_flag),
    .set_evt (hi_set),
    .clr_evt (hi_clr)
  );

  pair_hyst u_low (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (peak_detector_enable),
    .det     (det),
    .upper   (low_pair_upper_threshold),
    .lower   (low_pair_lower_threshold),
    .hold    (flag_release_hold_time),
    .flag    (low_flag),
    .set_evt (lo_set),
    .clr_evt (lo_clr)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_peak      <= '0;
      iir_feed       <= IIR_ZERO;
      iir_feed_valid <= 1'b0;
    end
    else
    begin
      iir_feed_valid <= det.block_done;
      if (det.block_done)
        last_peak <= det.block_peak;
      if (!iir_input_select)
        iir_feed <= {1'b0, high_flag}; // [R10]
      else if (high_flag)
        iir_feed <= IIR_POS; // [R11]
      else if (low_flag)
        iir_feed <= IIR_ZERO; // [R11]
      else
        iir_feed <= IIR_NEG; // [R11]
    end
  end

  always_comb
  begin
    events            = '0;
    events[ST_BLOCK]  = det.block_done;
    events[ST_HI_SET] = hi_set;
    events[ST_HI_CLR] = hi_clr;
    events[ST_LO_SET] = lo_set;
    events[ST_LO_CLR] = lo_clr;
  end

  // a new event in the read-clear cycle survives the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status <= '0;
    else if (status_rd)
      status <= (status & ~prdata[STAT_W-1:0]) | events;
    else
      status <= status | events;
  end

  assign irq = |(status & mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_block_length: assert property ( // [R1]
    det.block_done |-> $past(blk_cnt) == $past(len_eff) - BLOCK_LEN_W'(1))
    else $error("block ended at wrong length");
  a_block_restart: assert property ( // [R13]
    peak_detector_enable && red_valid && last
    |=> blk_cnt == '0 && det.block_peak == $past(next_acc))
    else $error("block did not restart");
  a_disabled_idle: assert property ( // [R12]
    !peak_detector_enable |=> !det.block_done && !high_flag && !low_flag)
    else $error("detector active while disabled");
  a_iir_high_only: assert property ( // [R10]
    !iir_input_select |=> iir_feed == {1'b0, $past(high_flag)})
    else $error("iir feed not high pair");
  a_iir_three_level: assert property ( // [R11]
    iir_input_select && !high_flag && !low_flag |=> iir_feed == IIR_NEG)
    else $error("iir feed not minus one");
  a_status_sticky: assert property (
    det.block_done |=> status[ST_BLOCK])
    else $error("block event lost");
endmodule : block_peak_detector
`default_nettype wire

// ===== verification/tb_top.sv
/*
  self-checking bench for the block peak detector: registers over apb,
  hysteresis flags, hold release, iir feed, interrupt and enable.
  assumes the design's zero-wait apb slave and its package constants.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import peak_det_pkg::*;
();
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        sample_valid;
  logic [13:0] sample;
  logic        high_flag;
  logic        low_flag;
  logic [1:0]  iir_feed;
  logic        iir_feed_valid;
  logic        irq;
  int          bad_count;
  int          compares;
  int          blocks;

  // magnitude is |s|>>5: 4096 gives 128, 1440 gives 45
  localparam logic [13:0] NEG = 14'h3000;
  localparam logic [13:0] MID = 14'h05a0;
  localparam logic [13:0] ZRO = 14'h0000;

  block_peak_detector #(.SAMPLE_W(14), .ADDR_W(12)) block_peak_detector_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .sample_valid(sample_valid), .sample(sample),
    .high_flag(high_flag), .low_flag(low_flag), .iir_feed(iir_feed),
    .iir_feed_valid(iir_feed_valid), .irq(irq));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (iir_feed_valid === 1'b1)
      blocks <= blocks + 1;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task complete_run;
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
           input logic [3:0] st, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h00_0000, d};
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a hung transfer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, 4'h1, r, e);
  endtask : wr

  task rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, 4'h0, r, e);
    check(r, exp);
    check({31'h0000_0000, e}, {31'h0000_0000, ee});
  endtask : rd_chk

  task feed(input logic [13:0] s, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      sample_valid <= 1'b1;
      sample       <= s;
    end
  endtask : feed

  task idle(input int n);
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : idle

  // one block of two groups; peak sits last in the first group
  task blk(input logic [13:0] s);
    feed(ZRO, 7);
    feed(s, 1);
    feed(ZRO, 8);
    idle(6);
  endtask : blk

  task flags(input logic h, input logic l, input logic [1:0] f);
    check({30'h0000_0000, high_flag, low_flag}, {30'h0000_0000, h, l});
    check({30'h0000_0000, iir_feed}, {30'h0000_0000, f});
  endtask : flags

  initial
  begin
    #(25 * 20000);
    bad_count++;
    complete_run();
  end

  initial
  begin
    logic [7:0]  idx_list [12];
    logic [31:0] rdum;
    logic        edum;
    idx_list = '{IDX_ENABLE, IDX_LEN_LO, IDX_LEN_MID, IDX_LEN_MSB, IDX_HI_UP,
                 IDX_HI_LOW, IDX_LO_UP, IDX_LO_LOW, IDX_HOLD_LO, IDX_HOLD_HI,
                 IDX_IIR_SEL, IDX_MASK};
    bad_count = 0;
    compares = 0;
    blocks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, sample_valid} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    sample = ZRO;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (idx_list[i])
      rd_chk(idx_list[i], 32'h0000_0000, 1'b0);
    rd_chk(8'h05, 32'h0000_0000, 1'b1);
    apb(1'b1, IDX_HI_UP, 8'h55, 4'h0, rdum, edum);
    check({31'h0000_0000, edum}, 32'h0000_0000);
    rd_chk(IDX_HI_UP, 32'h0000_0000, 1'b0);
    wr(IDX_LEN_MSB, 8'h01);
    rd_chk(IDX_LEN_MSB, 32'h0000_0001, 1'b0);
    wr(IDX_LEN_MSB, 8'h00);
    wr(IDX_LEN_LO, 8'h02);
    wr(IDX_HI_UP, 8'h64);
    wr(IDX_HI_LOW, 8'h32);
    wr(IDX_LO_UP, 8'h28);
    wr(IDX_LO_LOW, 8'h14);
    rd_chk(IDX_LO_LOW, 32'h0000_0014, 1'b0);
    wr(IDX_MASK, 8'h02);
    wr(IDX_ENABLE, 8'h01);
    // first group alone completes no block, so nothing may move
    feed(ZRO, 7);
    feed(NEG, 1);
    idle(6);
    flags(1'b0, 1'b0, 2'b00);
    feed(ZRO, 8);
    idle(6);
    flags(1'b1, 1'b1, 2'b01);
    check({31'h0000_0000, irq}, 32'h0000_0001);
    rd_chk(IDX_STATUS, 32'h0000_000b, 1'b0);
    rd_chk(IDX_PEAK, 32'h0003_0080, 1'b0);
    idle(1);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    wr(IDX_IIR_SEL, 8'h01);
    blk(MID);
    flags(1'b0, 1'b1, 2'b00);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    rd_chk(IDX_STATUS, 32'h0000_0005, 1'b0);
    blk(ZRO);
    flags(1'b0, 1'b0, 2'b11);
    rd_chk(IDX_STATUS, 32'h0000_0011, 1'b0);
    // hold of three reduced ticks after the dip block
    wr(IDX_IIR_SEL, 8'h00);
    wr(IDX_HOLD_LO, 8'h03);
    blk(NEG);
    flags(1'b1, 1'b1, 2'b01);
    blk(ZRO);
    flags(1'b1, 1'b1, 2'b01);
    blk(ZRO);
    flags(1'b1, 1'b1, 2'b01);
    feed(ZRO, 8);
    idle(6);
    flags(1'b0, 1'b0, 2'b00);
    feed(ZRO, 8);
    idle(6);
    blk(NEG);
    flags(1'b1, 1'b1, 2'b01);
    wr(IDX_ENABLE, 8'h00);
    idle(2);
    flags(1'b0, 1'b0, 2'b00);
    blk(NEG);
    flags(1'b0, 1'b0, 2'b00);
    check(blocks, 32'h0000_0008);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
